// *** hdl/var_shift_map.vh ***
// constants for the variable arithmetic right shift unit
// included by the unit only; definitions, no logic
`ifndef VAR_SHIFT_MAP_VH
`define VAR_SHIFT_MAP_VH
`define MAJOR_POS_HI       31
`define MAJOR_POS_LO       26
`define SRC_POS_HI         25
`define SRC_POS_LO         21
`define AMT_POS_HI         20
`define AMT_POS_LO         16
`define DST_POS_HI         15
`define DST_POS_LO         11
`define MINOR11_POS_HI     10
`define MINOR10_POS_HI     9
`define MINOR_POS_LO       0
`define MAJOR_GROUP_CODE   6'h00
`define MINOR11_PH         11'h18D
`define MINOR11_PH_ROUND   11'h58D
`define MINOR11_QB         11'h1CD
`define MINOR11_QB_ROUND   11'h5CD
`define MINOR10_W_ROUND    10'h2D5
`define W_ZERO_BIT         10
`define RESULT_RESET       32'h0000_0000
`define LATENCY_CYCLES     1
`endif

// *** hdl/var_arith_shift.v ***
// variable arithmetic right shift unit: packed halfword, packed byte and rounded word forms
// assumes the host pipeline presents one decoded instruction per cycle with both operands read
// results and trap pulses appear one cycle after the issue edge
// clock and asynchronous reset come from the host pipeline
// no software-visible registers
// What this block does
// - each halfword lane shifts right alone, refilling with its own sign
// - plain halfword form writes both shifted lanes unchanged to destination halfwords
// - rounding halfword form adds one at the top discarded bit per lane
// - halfword shift amount uses only bits 3..0 of the shift amount register
// - two 11-bit minor codes select plain and rounding halfword forms
// - each byte lane shifts right arithmetically by the same amount into its byte
// - byte shift amount is bits 2..0 of the amount register, zero to seven
// - rounding byte form adds one at the top discarded bit per byte
// - byte shift of zero returns source bytes unchanged in both forms
// - two 11-bit minor codes select plain and rounding byte forms
// - word form shifts the signed 32-bit source right with sign fill
// - word form adds one at the top discarded bit and writes the result
// - word shift amount uses bits 4..0 of the amount register
// - word form decodes from a 10-bit minor code with the bit above zero
// - no operation traps on data values, overflow or shift amount
// - reserved-instruction trap when extension absent, disabled trap when turned off
`timescale 1ns/1ps
`default_nettype none
`include "var_shift_map.vh"

module var_arith_shift #(
  parameter WIDTH = 32
) (
  input  wire              clock,
  input  wire              rst,
  input  wire              issue_valid,
  input  wire [31:0]       instr_word,
  input  wire [WIDTH-1:0]  source_operand_reg,
  input  wire [WIDTH-1:0]  shift_amount_reg,
  input  wire              ext_present,
  input  wire              ext_enabled,
  output reg               result_valid_q,
  output reg  [WIDTH-1:0]  result_q,
  output reg  [4:0]        dest_index_q,
  output reg               reserved_instr_exc_q,
  output reg               dsp_disabled_exc_q,
  output reg               op_hit_q
);

  // decoded operation codes
  localparam OP_NONE  = 3'h0;
  localparam OP_PH    = 3'h1;
  localparam OP_PH_R  = 3'h2;
  localparam OP_QB    = 3'h3;
  localparam OP_QB_R  = 3'h4;
  localparam OP_W_R   = 3'h5;

  // lane widths of the packed formats
  localparam HALF_W   = 16;
  localparam BYTE_W   = 8;
  localparam WORD_W   = 32;

  // each lane is widened by one low bit so that the rounding carry stays inside the lane
  function [HALF_W-1:0] shift16;
    input [HALF_W-1:0] a;
    input [3:0]        s;
    input              rnd;
    reg   [HALF_W:0]   wide;
    begin
      if (s == 4'h0) begin
        wide = {a, 1'b0};
      end else begin
        wide = $signed({a, 1'b0}) >>> s;
        if (rnd) begin
          wide = wide + 17'h00001;
        end
      end
      shift16 = wide[HALF_W:1];
    end
  endfunction

  // bytes follow the same scheme with a three-bit amount
  function [BYTE_W-1:0] shift8;
    input [BYTE_W-1:0] a;
    input [2:0]        s;
    input              rnd;
    reg   [BYTE_W:0]   wide;
    begin
      if (s == 3'h0) begin
        wide = {a, 1'b0};
      end else begin
        wide = $signed({a, 1'b0}) >>> s;
        if (rnd) begin
          wide = wide + 9'h001;
        end
      end
      shift8 = wide[BYTE_W:1];
    end
  endfunction

  // the word form always rounds; at amount zero the added one would only touch the dropped
  // bit, so that case is taken as a plain copy
  function [WORD_W-1:0] shift32r;
    input [WORD_W-1:0] a;
    input [4:0]        s;
    reg   [WORD_W:0]   wide;
    begin
      if (s == 5'h00) begin
        wide = {a, 1'b0};
      end else begin
        wide = $signed({a, 1'b0}) >>> s;
        wide = wide + 33'h000000001;
      end
      shift32r = wide[WORD_W:1];
    end
  endfunction

  // instruction fields
  wire [5:0]       major_code;
  wire [4:0]       dest_field;
  wire [10:0]      minor11;
  wire [9:0]       minor10;
  wire             word_zero_bit;

  assign major_code    = instr_word[`MAJOR_POS_HI:`MAJOR_POS_LO];
  assign dest_field    = instr_word[`DST_POS_HI:`DST_POS_LO];
  assign minor11       = instr_word[`MINOR11_POS_HI:`MINOR_POS_LO];
  assign minor10       = instr_word[`MINOR10_POS_HI:`MINOR_POS_LO];
  assign word_zero_bit = instr_word[`W_ZERO_BIT];

  // one flag per recognised opcode; the codes never overlap, so at most one is high
  wire             group_ok;
  wire             is_ph;
  wire             is_ph_r;
  wire             is_qb;
  wire             is_qb_r;
  wire             is_w_r;

  assign group_ok = (major_code == `MAJOR_GROUP_CODE);
  assign is_ph    = group_ok && (minor11 == `MINOR11_PH);
  assign is_ph_r  = group_ok && (minor11 == `MINOR11_PH_ROUND);
  assign is_qb    = group_ok && (minor11 == `MINOR11_QB);
  assign is_qb_r  = group_ok && (minor11 == `MINOR11_QB_ROUND);
  assign is_w_r   = group_ok && !word_zero_bit && (minor10 == `MINOR10_W_ROUND);

  // the order of the chain is moot since the flags exclude one another
  reg  [2:0]       op_d;

  always @* begin
    op_d = OP_NONE;
    if (is_ph) begin
      op_d = OP_PH;
    end else if (is_ph_r) begin
      op_d = OP_PH_R;
    end else if (is_qb) begin
      op_d = OP_QB;
    end else if (is_qb_r) begin
      op_d = OP_QB_R;
    end else if (is_w_r) begin
      op_d = OP_W_R;
    end
  end

  // each form reads only its own low bits of the amount register
  wire [3:0]       amt_half;
  wire [2:0]       amt_byte;
  wire [4:0]       amt_word;
  wire             round_half;
  wire             round_byte;

  assign amt_half   = shift_amount_reg[3:0];
  assign amt_byte   = shift_amount_reg[2:0];
  assign amt_word   = shift_amount_reg[4:0];
  assign round_half = (op_d == OP_PH_R);
  assign round_byte = (op_d == OP_QB_R);

  // lane results, each formed alone so nothing carries across a lane boundary
  wire [15:0]      half_hi;
  wire [15:0]      half_lo;
  wire [7:0]       byte_3;
  wire [7:0]       byte_2;
  wire [7:0]       byte_1;
  wire [7:0]       byte_0;
  wire [31:0]      word_r;

  assign half_hi = shift16(source_operand_reg[31:16], amt_half, round_half);
  assign half_lo = shift16(source_operand_reg[15:0], amt_half, round_half);
  assign byte_3  = shift8(source_operand_reg[31:24], amt_byte, round_byte);
  assign byte_2  = shift8(source_operand_reg[23:16], amt_byte, round_byte);
  assign byte_1  = shift8(source_operand_reg[15:8], amt_byte, round_byte);
  assign byte_0  = shift8(source_operand_reg[7:0], amt_byte, round_byte);
  assign word_r  = shift32r(source_operand_reg[31:0], amt_word);

  // forms that are not decoded produce zero
  reg  [WIDTH-1:0] res_d;

  always @* begin
    res_d = `RESULT_RESET;
    case (op_d)
      OP_PH, OP_PH_R: begin
        res_d[31:16] = half_hi;
        res_d[15:0]  = half_lo;
      end
      OP_QB, OP_QB_R: begin
        res_d[31:24] = byte_3;
        res_d[23:16] = byte_2;
        res_d[15:8]  = byte_1;
        res_d[7:0]   = byte_0;
      end
      OP_W_R: begin
        res_d = word_r;
      end
      default: begin
        res_d = `RESULT_RESET;
      end
    endcase
  end

  // traps depend only on decode and extension state, never on operand data
  // an absent extension wins over a disabled one, so at most one trap pulses
  wire             hit;
  wire             trap_absent;
  wire             trap_disabled;
  wire             write_ok;

  assign hit           = issue_valid && (op_d != OP_NONE);
  assign trap_absent   = hit && !ext_present;
  assign trap_disabled = hit && ext_present && !ext_enabled;
  assign write_ok      = hit && ext_present && ext_enabled;

  reg              op_hit_d;
  reg              reserved_instr_exc_d;
  reg              dsp_disabled_exc_d;
  reg              result_valid_d;
  reg  [4:0]       dest_index_d;
  reg  [WIDTH-1:0] result_d;

  // next values of the registered outputs; the result holds unless a decoded op is issued
  always @* begin
    op_hit_d             = hit;
    reserved_instr_exc_d = trap_absent;
    dsp_disabled_exc_d   = trap_disabled;
    result_valid_d       = write_ok;
    dest_index_d         = dest_field;
    result_d             = result_q;
    if (hit) begin
      result_d = res_d;
    end
  end

  // every output is a flop of its own; all clear together on reset
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      op_hit_q <= 1'b0;
    end else begin
      op_hit_q <= op_hit_d;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      reserved_instr_exc_q <= 1'b0;
    end else begin
      reserved_instr_exc_q <= reserved_instr_exc_d;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      dsp_disabled_exc_q <= 1'b0;
    end else begin
      dsp_disabled_exc_q <= dsp_disabled_exc_d;
    end
  end

  // the write strobe is the only pulse that tells the register file to take the result
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      result_valid_q <= 1'b0;
    end else begin
      result_valid_q <= result_valid_d;
    end
  end

  // dest index follows every cycle, so it only means something alongside a pulse
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      dest_index_q <= 5'h00;
    end else begin
      dest_index_q <= dest_index_d;
    end
  end

  // the result also moves on a trapped op; the write port must gate on result_valid_q
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      result_q <= `RESULT_RESET;
    end else begin
      result_q <= result_d;
    end
  end

endmodule // var_arith_shift
`default_nettype wire

// *** tb/shift_issuer.sv ***
// decoder-side model: packs an op choice and a dest index into an instruction word
// assumes ops 0..4 are the five shifts and 5..7 unmatched codes
`timescale 1ns/1ps
`default_nettype none
module shift_issuer (
  input  wire logic [2:0]  op,
  input  wire logic [4:0]  rd,
  output logic      [31:0] instr_word
);
  logic [10:0] minor;
  always_comb begin
    case (op)
      3'h0: minor = 11'h18D;
      3'h1: minor = 11'h58D;
      3'h2: minor = 11'h1CD;
      3'h3: minor = 11'h5CD;
      3'h4: minor = 11'h2D5;
      default: minor = 11'h6D5; // bit above the word code set, so nothing decodes
    endcase
  end
  // operands arrive already packed from the bench
  assign instr_word = {6'h00, 5'h03, 5'h04, rd, minor};
endmodule // shift_issuer
`default_nettype wire

// *** tb/var_arith_shift_assertions.sv ***
// checker for the shift unit: decode, trap and result timing at its ports
// bound to the unit from the bench; one clock, async reset
`timescale 1ns/1ps
`default_nettype none
module var_arith_shift_assertions (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        issue_valid,
  input wire logic        ext_present,
  input wire logic        ext_enabled,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] source_operand_reg,
  input wire logic [31:0] shift_amount_reg,
  input wire logic [31:0] result_q,
  input wire logic        result_valid_q,
  input wire logic        reserved_instr_exc_q,
  input wire logic        dsp_disabled_exc_q,
  input wire logic        op_hit_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire logic [10:0] m = instr_word[10:0];
  wire logic hit = issue_valid && instr_word[31:26] == 6'h00 && (m == 11'h18D
    || m == 11'h58D || m == 11'h1CD || m == 11'h5CD || m == 11'h2D5);
  sequence s_hit; hit; endsequence
  sequence s_live; hit && ext_present && ext_enabled; endsequence
  chk_hit_flag: assert property (s_hit |=> op_hit_q) else $error("no hit flag");
  chk_miss_quiet: assert property (!hit |=> !op_hit_q && !result_valid_q)
    else $error("pulse on miss");
  chk_live_write: assert property (s_live |=> result_valid_q && !reserved_instr_exc_q
    && !dsp_disabled_exc_q) else $error("live op not written");
  chk_absent_trap: assert property (s_hit ##0 !ext_present |=> reserved_instr_exc_q
    && !result_valid_q) else $error("absent trap");
  chk_off_trap: assert property (hit && ext_present && !ext_enabled |=> dsp_disabled_exc_q
    && !result_valid_q) else $error("disabled trap");
  chk_held_result: assert property (!hit |=> $stable(result_q)) else $error("result moved");
  chk_byte_zero: assert property (s_live ##0 m == 11'h1CD && shift_amount_reg[2:0] == 3'h0
    |=> result_q == $past(source_operand_reg)) else $error("byte zero");
  chk_word_full: assert property (s_live ##0 m == 11'h2D5 && shift_amount_reg[4:0] == 5'h1F
    |=> result_q <= 32'h1 || result_q == 32'hFFFFFFFF) else $error("word sign fill");
endmodule // var_arith_shift_assertions
`default_nettype wire

// *** tb/variable_arith_right_shift_unit_tb.sv ***
// bench for the shift unit: corner then random shifts, checked one cycle after issue
// assumes the unit answers on the taking edge itself, read back 1 ns after that edge
`timescale 1ns/1ps
`default_nettype none
module variable_arith_right_shift_unit_tb;
  logic        clock = 0, rst = 1, iv = 0, pres = 0, en = 0, hit = 0, rv, re, de, oh;
  logic [2:0]  op = 0;
  logic [4:0]  rd = 0, di;
  logic [31:0] a = 0, b = 0, iw, r, last = 0;
  integer      fails = 0, total_checks = 0, seed = 32'hADB5, cyc = 0, i;
  initial forever #4 clock = ~clock;
  always @(posedge clock) if (++cyc > 1000) begin fails++; print_verdict; end
  shift_issuer shift_issuer_inst (.op(op), .rd(rd), .instr_word(iw));
  var_arith_shift var_arith_shift_inst (.clock(clock), .rst(rst), .issue_valid(iv),
    .instr_word(iw), .source_operand_reg(a), .shift_amount_reg(b), .ext_present(pres),
    .ext_enabled(en), .result_valid_q(rv), .result_q(r), .dest_index_q(di),
    .reserved_instr_exc_q(re), .dsp_disabled_exc_q(de), .op_hit_q(oh));
  task check(input [31:0] seen, input [31:0] want);
    total_checks++;
    if (seen !== want) begin
      fails++;
      $display("Error %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task print_verdict;
    if (fails == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function [31:0] lane(input [31:0] x, input integer w, s, input rnd);
    reg signed [32:0] t;
    begin
      t = {x, 1'b0} << (32 - w);
      t = t >>> (32 - w + s);
      t = t + rnd; // extra low bit keeps the round carry inside the lane
      lane = t[32:1] << (32 - w);
    end
  endfunction
  function [31:0] expect_f(input [2:0] o, input [31:0] x, input [31:0] y);
    integer w, k;
    begin
      w = o < 2 ? 16 : o < 4 ? 8 : 32;
      expect_f = 0;
      for (k = 0; k < 32; k += w)
        expect_f = expect_f | lane(x >> k, w, y & (w - 1), o[0] | o[2]) >> (32 - w - k);
    end
  endfunction
  initial begin
    repeat (5) @(posedge clock);
    #1 rst = 0;
    for (i = 0; i < 600; i++) begin
      @(posedge clock);
      #1;
      check(oh, hit);
      check(rv, hit & pres & en);
      check({re, de}, {hit & ~pres, hit & pres & ~en});
      check(di, rd);
      if (hit) last = expect_f(op, a, b);
      check(r, last);
      iv = i < 40 || $random(seed) % 4 != 0;
      op = i < 40 ? i % 8 : $random(seed);
      rd = $random(seed);
      a = i < 40 ? 32'h8001_7F80 : $random(seed);
      b = i < 20 ? 32'hFFFF_FFE0 : i < 40 ? 32'hFFFF_FFFF : $random(seed);
      pres = i < 40 || $random(seed) % 8 != 0;
      en = i < 40 || $random(seed) % 8 != 0;
      hit = iv && op < 5;
    end
    print_verdict;
  end
endmodule // variable_arith_right_shift_unit_tb
bind var_arith_shift var_arith_shift_assertions var_arith_shift_assertions_inst (
  .clock(clock), .rst(rst), .issue_valid(issue_valid), .ext_present(ext_present),
  .ext_enabled(ext_enabled), .instr_word(instr_word), .source_operand_reg(source_operand_reg),
  .shift_amount_reg(shift_amount_reg), .result_q(result_q), .result_valid_q(result_valid_q),
  .reserved_instr_exc_q(reserved_instr_exc_q), .dsp_disabled_exc_q(dsp_disabled_exc_q),
  .op_hit_q(op_hit_q));
`default_nettype wire
